// file: design/trig_seq.sv
/*
 * Acquisition/frame trigger sequencer with Avalon-MM register slave.
 * Assumes input lines are asynchronous and the bus master follows
 * Avalon waitrequest signalling on the same clock.
 */
// The address map and the Avalon-MM register port were chosen for this implementation.
// Summary of operation
// - acquisition edge on selected line moves wait-acquisition to wait-frame.
// - acquisition edge polarity selectable, rising edge supported.
// - burst count reached returns to wait-acquisition.
// - frame triggering off means frames start internally.
// - internal frame starts paced by rate period when rate enabled.
// - rate disabled means frames at minimum frame period.
// - software command acts as acquisition start trigger.
// - frame triggers honoured only in wait-frame state.
// - frame triggers while waiting for acquisition are dropped.
// - external burst ends after programmed frame triggers accepted.
// - bursts run only under continuous policy; modes pick sources.
// - both levels off under continuous acquires constantly.
// - legacy control drops acquisition level, per-frame trigger remains.
`timescale 1ns/1ps
module trig_seq
   import trig_seq_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [DATA_W-1:0] writedata,
   output logic [DATA_W-1:0] readdata,
   output logic waitrequest,
   input wire logic [NUM_LINES-1:0] line_in,
   output logic frame_start,
   output logic frame_active,
   output logic wait_acq,
   output logic wait_frm
);
   // line synchronisers and edge detection
   logic [NUM_LINES-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;
   logic [NUM_LINES-1:0] rise, fall;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_LINES; gi++) begin : g_line
         always_comb begin
            lvl_d[gi] = lvl_q[gi];
            if (s2_q[gi] == s3_q[gi]) begin
               lvl_d[gi] = s3_q[gi];
            end
            rise[gi] = lvl_d[gi] & ~lvl_q[gi];
            fall[gi] = ~lvl_d[gi] & lvl_q[gi];
         end
      end
   endgenerate

   always_ff @(posedge clk) begin
      if (!rstn) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         lvl_q <= '0;
      end else begin
         s1_q <= line_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= lvl_d;
      end
   end

   // registers and bus slave
   ctrl_t ctrl_q, ctrl_d;
   logic [CNT_W-1:0] burst_q, burst_d;
   logic [DATA_W-1:0] rate_q, rate_d, minp_q, minp_d, rdata_q, rdata_d;
   logic wr_q, wr_d, ign_q, ign_d, sw_acq;
   logic [2:0] idx;
   logic take, grant;
   state_t state_q, state_d;
   logic [CNT_W-1:0] frames_q, frames_d;
   logic [DATA_W-1:0] pace_q, pace_d, dwell_q, dwell_d;
   logic fs_q, fs_d, ign_ev;

   assign idx = address[IDX_LSB+2:IDX_LSB];
   assign grant = (read | write) & wr_q;
   assign take = (read | write) & ~wr_q;

   always_comb begin
      ctrl_d = ctrl_q;
      burst_d = burst_q;
      rate_d = rate_q;
      minp_d = minp_q;
      wr_d = 1'b1;
      rdata_d = rdata_q;
      sw_acq = 1'b0;
      ign_d = ign_q;
      if (grant) begin
         wr_d = 1'b0;
      end
      // read data only moves on a read
      if (grant && read) begin
         rdata_d = '0;
         case (idx)
            REG_CTRL: rdata_d[CTRL_W-1:0] = ctrl_q;
            REG_BURST: rdata_d[CNT_W-1:0] = burst_q;
            REG_RATE: rdata_d = rate_q;
            REG_MINP: rdata_d = minp_q;
            REG_STAT: begin
               rdata_d[1:0] = state_q;
               rdata_d[STAT_IGN] = ign_q;
               rdata_d[STAT_CNT_LSB +: CNT_W] = frames_q;
            end
            default: rdata_d = '0;
         endcase
      end
      if (take && write) begin
         case (idx)
            REG_CTRL: ctrl_d = writedata[CTRL_W-1:0];
            REG_CMD: sw_acq = writedata[CMD_SW_ACQ];
            REG_BURST: burst_d = writedata[CNT_W-1:0];
            REG_RATE: rate_d = writedata;
            REG_MINP: minp_d = writedata;
            REG_STAT: begin
               if (writedata[STAT_IGN]) begin
                  ign_d = 1'b0;
               end
            end
            default: ;
         endcase
      end
      // dropped trigger flag, set wins over clear
      if (ign_ev) begin
         ign_d = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         ctrl_q <= CTRL_RST;
         burst_q <= BURST_RST;
         rate_q <= RATE_RST;
         minp_q <= MINP_RST;
         wr_q <= 1'b1;
         rdata_q <= '0;
         ign_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         burst_q <= burst_d;
         rate_q <= rate_d;
         minp_q <= minp_d;
         wr_q <= wr_d;
         rdata_q <= rdata_d;
         ign_q <= ign_d;
      end
   end

   // trigger sequencer
   logic acq_eff, acq_edge, acq_trig, frm_edge, frm_trig, burst_done;

   assign acq_eff = ctrl_q.acq_on & ~ctrl_q.legacy;
   assign acq_edge = ctrl_q.acq_fall ? fall[ctrl_q.acq_sel] : rise[ctrl_q.acq_sel];
   assign frm_edge = ctrl_q.frm_fall ? fall[ctrl_q.frm_sel] : rise[ctrl_q.frm_sel];
   assign acq_trig = ~acq_eff | (ctrl_q.acq_sw ? sw_acq : acq_edge);
   // rate off runs at minimum period
   assign frm_trig = ctrl_q.frm_on ? frm_edge
                   : (~ctrl_q.rate_en | (pace_q >= rate_q));
   assign burst_done = frames_q >= burst_q;
   // external frame edge outside the wait-frame state
   assign ign_ev = ctrl_q.frm_on & frm_edge & (state_q != ST_WAIT_FRM);

   always_comb begin
      state_d = state_q;
      frames_d = frames_q;
      fs_d = 1'b0;
      dwell_d = dwell_q;
      pace_d = (pace_q == '1) ? pace_q : pace_q + ONE;
      case (state_q)
         ST_IDLE: begin
            if (ctrl_q.cont) begin
               state_d = ST_WAIT_ACQ;
            end
         end
         ST_WAIT_ACQ: begin
            if (acq_trig) begin
               state_d = ST_WAIT_FRM;
               frames_d = '0;
            end
         end
         ST_WAIT_FRM: begin
            if (frm_trig) begin
               state_d = ST_FRAME;
               fs_d = 1'b1;
               frames_d = frames_q + 16'h0001;
               pace_d = ONE;
               dwell_d = (minp_q == '0) ? ONE : minp_q;
            end
         end
         ST_FRAME: begin
            dwell_d = dwell_q - ONE;
            if (dwell_q <= ONE) begin
               state_d = burst_done ? ST_WAIT_ACQ : ST_WAIT_FRM;
            end
         end
         default: state_d = ST_IDLE;
      endcase
      if (!ctrl_q.cont && state_q != ST_FRAME) begin
         state_d = ST_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_q <= ST_IDLE;
         frames_q <= '0;
         pace_q <= '0;
         dwell_q <= '0;
         fs_q <= 1'b0;
      end else begin
         state_q <= state_d;
         frames_q <= frames_d;
         pace_q <= pace_d;
         dwell_q <= dwell_d;
         fs_q <= fs_d;
      end
   end

   logic wacq_q, wfrm_q, fact_q;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         wacq_q <= 1'b0;
         wfrm_q <= 1'b0;
         fact_q <= 1'b0;
      end else begin
         wacq_q <= state_d == ST_WAIT_ACQ;
         wfrm_q <= state_d == ST_WAIT_FRM;
         fact_q <= state_d == ST_FRAME;
      end
   end

   assign readdata = rdata_q;
   assign waitrequest = wr_q;
   assign frame_start = fs_q;
   assign frame_active = fact_q;
   assign wait_acq = wacq_q;
   assign wait_frm = wfrm_q;

   AST_ACQ_LINE: assert property (@(posedge clk) disable iff (!rstn)
      state_q == ST_WAIT_ACQ && ctrl_q.cont && acq_eff && !ctrl_q.acq_sw && acq_edge
      |=> state_q == ST_WAIT_FRM && wait_frm)
      else $error("line acquisition edge did not open a burst");
   AST_ACQ_POL: assert property (@(posedge clk) disable iff (!rstn)
      state_q == ST_WAIT_ACQ && ctrl_q.cont && acq_eff && !ctrl_q.acq_sw && !acq_edge
      |=> state_q == ST_WAIT_ACQ)
      else $error("burst opened without selected edge");
   AST_BURST_END: assert property (@(posedge clk) disable iff (!rstn)
      state_q == ST_FRAME && dwell_q <= ONE && burst_done |=> state_q == ST_WAIT_ACQ)
      else $error("burst did not end at programmed count");
   AST_FREE_RUN: assert property (@(posedge clk) disable iff (!rstn)
      state_q == ST_WAIT_FRM && ctrl_q.cont && !ctrl_q.frm_on && !ctrl_q.rate_en
      |=> frame_start && frame_active)
      else $error("internal frame start missing");
   AST_PACE: assert property (@(posedge clk) disable iff (!rstn)
      frame_start && !$past(ctrl_q.frm_on) && $past(ctrl_q.rate_en)
      |-> $past(pace_q) >= $past(rate_q))
      else $error("internal frame start faster than rate period");
   AST_SW_ACQ: assert property (@(posedge clk) disable iff (!rstn)
      state_q == ST_WAIT_ACQ && ctrl_q.cont && acq_eff && ctrl_q.acq_sw && sw_acq
      |=> state_q == ST_WAIT_FRM)
      else $error("software command did not open a burst");
   AST_ONLY_WAIT: assert property (@(posedge clk) disable iff (!rstn)
      frame_start |-> $past(state_q) == ST_WAIT_FRM)
      else $error("frame started outside wait-frame state");
   AST_IGNORE: assert property (@(posedge clk) disable iff (!rstn)
      state_q == ST_WAIT_ACQ && ctrl_q.frm_on && frm_edge |=> !frame_start && ign_q)
      else $error("frame trigger not dropped while waiting for acquisition");
   AST_POLICY: assert property (@(posedge clk) disable iff (!rstn)
      !ctrl_q.cont && state_q != ST_FRAME |=> state_q == ST_IDLE)
      else $error("sequencer active without continuous policy");
   AST_LEGACY: assert property (@(posedge clk) disable iff (!rstn)
      ctrl_q.legacy && ctrl_q.cont && state_q == ST_WAIT_ACQ |=> state_q == ST_WAIT_FRM)
      else $error("legacy mode waited for acquisition trigger");
   AST_CNT_CLR: assert property (@(posedge clk) disable iff (!rstn)
      state_q == ST_WAIT_ACQ && state_d == ST_WAIT_FRM |=> frames_q == '0)
      else $error("frame counter not cleared at burst start");
   AST_EXT_END: assert property (@(posedge clk) disable iff (!rstn)
      state_q == ST_FRAME && ctrl_q.frm_on && dwell_q <= ONE && frames_q >= burst_q
      |=> wait_acq)
      else $error("external burst did not end at programmed count");
   AST_FREE_ACQ: assert property (@(posedge clk) disable iff (!rstn)
      state_q == ST_WAIT_ACQ && ctrl_q.cont && !ctrl_q.acq_on |=> state_q == ST_WAIT_FRM)
      else $error("acquisition start not generated internally");
   AST_BUS_ACK: assert property (@(posedge clk) disable iff (!rstn)
      (read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
      else $error("bus answer not given in one cycle");
endmodule

// file: design/trig_seq_pkg.sv
/*
 * Constants, register map and types of the acquisition/frame trigger
 * sequencer. Assumes a single 250 MHz clock and a 32-bit Avalon-MM bus.
 */
package trig_seq_pkg;
   localparam int CLK_MHZ = 250;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;
   localparam int NUM_LINES = 4;
   localparam int SEL_W = 2;
   localparam int CNT_W = 16;

   // word index, byte address is four times this
   localparam logic [2:0] REG_CTRL = 3'h0;
   localparam logic [2:0] REG_CMD = 3'h1;
   localparam logic [2:0] REG_BURST = 3'h2;
   localparam logic [2:0] REG_RATE = 3'h3;
   localparam logic [2:0] REG_MINP = 3'h4;
   localparam logic [2:0] REG_STAT = 3'h5;
   localparam int IDX_LSB = 2;

   localparam int CMD_SW_ACQ = 0;
   localparam int STAT_IGN = 2;
   localparam int STAT_CNT_LSB = 16;
   localparam int CTRL_W = 12;

   typedef struct packed {
      logic [SEL_W-1:0] frm_sel;
      logic [SEL_W-1:0] acq_sel;
      logic frm_fall;
      logic acq_fall;
      logic acq_sw;
      logic rate_en;
      logic legacy;
      logic frm_on;
      logic acq_on;
      logic cont;
   } ctrl_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT_ACQ = 2'b01,
      ST_WAIT_FRM = 2'b10,
      ST_FRAME = 2'b11
   } state_t;

   localparam logic [CTRL_W-1:0] CTRL_RST = 12'h001;
   localparam logic [CNT_W-1:0] BURST_RST = 16'h0001;
   localparam logic [DATA_W-1:0] RATE_RST = 32'h0000_0100;
   localparam logic [DATA_W-1:0] MINP_RST = 32'h0000_0010;
   localparam logic [DATA_W-1:0] ONE = 32'h0000_0001;
endpackage

// file: verification/acquisition_frame_trigger_sequencer_bench.sv
/*
 * Self-checking bench of the trigger sequencer: Avalon-MM register tasks
 * and burst scenarios. Assumes the line model in trig_line_src.sv.
 */
`timescale 1ns/1ps
module acquisition_frame_trigger_sequencer_bench
   import trig_seq_pkg::*;
;
   logic clk;
   logic rstn;
   logic [ADDR_W-1:0] address;
   logic read;
   logic write;
   logic [DATA_W-1:0] writedata;
   logic [DATA_W-1:0] readdata;
   logic waitrequest;
   logic [NUM_LINES-1:0] line_in;
   logic [NUM_LINES-1:0] pulse_req;
   logic frame_start;
   logic frame_active;
   logic wait_acq;
   logic wait_frm;
   int n_fail;
   int checks_done;
   int cycles;
   int n_frm;
   int f0;
   int n_act;
   int a0;
   time t_last;
   time t_gap;

   trig_seq i_dut (.clk(clk), .rstn(rstn), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .line_in(line_in), .frame_start(frame_start), .frame_active(frame_active),
      .wait_acq(wait_acq), .wait_frm(wait_frm));

   trig_line_src i_src (.clk(clk), .pulse_req(pulse_req), .line_in(line_in));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic test_done;
      if (n_fail == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic bus(input logic wr, input logic [2:0] idx, input logic [31:0] wd,
      output logic [31:0] rd);
      @(posedge clk);
      address <= {idx, 2'b00};
      write <= wr;
      read <= !wr;
      writedata <= wd;
      do begin
         @(posedge clk);
      end while (waitrequest !== 1'b0);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic wr(input logic [2:0] idx, input logic [31:0] wd);
      logic [31:0] rd;
      bus(1'b1, idx, wd, rd);
   endtask

   task automatic rdchk(input logic [2:0] idx, input logic [31:0] exp);
      logic [31:0] rd;
      bus(1'b0, idx, 32'h0000_0000, rd);
      chk(rd, exp);
   endtask

   task automatic pulse(input logic [NUM_LINES-1:0] m);
      @(posedge clk);
      pulse_req <= m;
      @(posedge clk);
      pulse_req <= '0;
      repeat (40) @(posedge clk);
   endtask

   task automatic wait_acq_hi;
      while (wait_acq !== 1'b1) begin
         @(posedge clk);
      end
   endtask

   always @(posedge clk) begin
      cycles++;
      if (frame_start === 1'b1) begin
         n_frm++;
         t_gap = $time - t_last;
         t_last = $time;
      end
      if (frame_active === 1'b1) begin
         n_act++;
      end
      if (cycles > 20000) begin
         n_fail++;
         test_done();
      end
   end

   initial begin
      rstn = 1'b0;
      address = '0;
      read = 1'b0;
      write = 1'b0;
      writedata = '0;
      pulse_req = '0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      rdchk(REG_CTRL, 32'(CTRL_RST)); // reset register values
      rdchk(REG_BURST, 32'(BURST_RST));
      rdchk(REG_RATE, RATE_RST);
      rdchk(REG_MINP, MINP_RST);
      rdchk(REG_CMD, 32'h0000_0000);
      rdchk(3'h6, 32'h0000_0000);
      // free run with both levels off
      f0 = n_frm;
      repeat (200) @(posedge clk);
      chk(32'(n_frm > f0 + 4), 32'h0000_0001);
      wr(REG_MINP, 32'h0000_0004);
      wr(REG_BURST, 32'h0000_0003);
      wr(REG_CTRL, 32'h0000_0003);
      wait_acq_hi();
      // two bursts of three, each started by a rising edge on line 0
      for (int b = 0; b < 2; b++) begin
         f0 = n_frm;
         pulse(4'h1);
         repeat (60) @(posedge clk);
         chk(32'(n_frm - f0), 32'h0000_0003);
         chk({31'h0, wait_acq}, 32'h0000_0001);
         rdchk(REG_STAT, 32'h0003_0001);
      end
      repeat (100) @(posedge clk);
      chk(32'(n_frm - f0), 32'h0000_0003);
      // falling edge on line 2 opens the burst, its rising edge does not
      wr(REG_CTRL, 32'h0000_0243);
      f0 = n_frm;
      @(posedge clk);
      pulse_req <= 4'h4;
      @(posedge clk);
      pulse_req <= '0;
      repeat (6) @(posedge clk);
      chk({31'h0, wait_acq}, 32'h0000_0001);
      repeat (60) @(posedge clk);
      chk(32'(n_frm - f0), 32'h0000_0003);
      // software start, frame edges on line 1
      wr(REG_CTRL, 32'h0000_0427);
      f0 = n_frm;
      pulse(4'h2);
      chk(32'(n_frm - f0), 32'h0000_0000);
      rdchk(REG_STAT, 32'h0003_0005);
      wr(REG_STAT, 32'h0000_0004);
      wr(REG_CMD, 32'h0000_0001);
      repeat (10) @(posedge clk);
      chk({31'h0, wait_frm}, 32'h0000_0001);
      for (int i = 1; i <= 4; i++) begin
         pulse(4'h2);
         chk(32'(n_frm - f0), 32'((i > 3) ? 3 : i));
      end
      chk({31'h0, wait_acq}, 32'h0000_0001);
      // legacy control: frame edges on line 1, no acquisition level
      wr(REG_CTRL, 32'h0000_040F);
      f0 = n_frm;
      a0 = n_act;
      pulse(4'h2);
      chk(32'(n_frm - f0), 32'h0000_0001);
      chk(32'(n_act - a0), 32'h0000_0004);
      // internal pacing with and without the rate setting
      wr(REG_RATE, 32'h0000_0014);
      wr(REG_CTRL, 32'h0000_0011);
      repeat (200) @(posedge clk);
      chk(32'(t_gap / 4), 32'h0000_0014);
      wr(REG_CTRL, 32'h0000_0001);
      repeat (200) @(posedge clk);
      chk(32'(t_gap < 80), 32'h0000_0001);
      // policy off: sequencer parks in idle
      wr(REG_CTRL, 32'h0000_0000);
      repeat (20) @(posedge clk);
      f0 = n_frm;
      repeat (100) @(posedge clk);
      chk(32'(n_frm - f0), 32'h0000_0000);
      chk({29'h0, wait_acq, wait_frm, frame_active}, 32'h0000_0000);
      test_done();
   end
endmodule

// file: verification/trig_line_src.sv
/*
 * Model of the outside sensor/encoder that drives the trigger lines.
 * Assumes the bench asks for one pulse at a time on the lines it names.
 */
`timescale 1ns/1ps
module trig_line_src
   import trig_seq_pkg::*;
(
   input wire logic clk,
   input wire logic [NUM_LINES-1:0] pulse_req,
   output logic [NUM_LINES-1:0] line_in
);
   logic [3:0] cnt_q = 4'h0;
   logic [NUM_LINES-1:0] hold_q = '0;

   always_ff @(posedge clk) begin
      if (pulse_req != '0) begin
         hold_q <= pulse_req;
         cnt_q <= 4'h6;
      end else if (cnt_q != 4'h0) begin
         cnt_q <= cnt_q - 4'h1;
      end
   end

   // lines idle low between pulses
   assign line_in = (cnt_q != 4'h0) ? hold_q : '0;
endmodule
